// [design/isp_pkg.sv]
// constants and carriers of the i2c serial port control block
// assumes one 250 MHz clock and a byte-wide register port
package isp_pkg;
  // register indices on the local port
  localparam logic [2:0] OFS_STAT = 3'h0;
  localparam logic [2:0] OFS_CON1 = 3'h1;
  localparam logic [2:0] OFS_CON2 = 3'h2;
  localparam logic [2:0] OFS_ADDR = 3'h3;
  localparam logic [2:0] OFS_BUF  = 3'h4;
  localparam logic [2:0] OFS_IRQ  = 3'h5;
  // status bit positions
  localparam int B_BF = 0;
  localparam int B_UA = 1;
  // control one bit positions
  localparam int B_WRITE_COLLISION_FLAG = 7;
  localparam int B_OV   = 6;
  localparam int B_EN   = 5;
  localparam int B_CKP  = 4;
  // control two bit positions
  localparam int B_GENERAL_CALL_ENABLE = 7;
  localparam int B_AST  = 6;
  localparam int B_ADT  = 5;
  localparam int B_SEN  = 0;
  // reset value of all control registers
  localparam logic [7:0] CON_RST = 8'h00;
  // mode codes
  localparam logic [3:0] MODE_S10I = 4'hf;
  localparam logic [3:0] MODE_S7I  = 4'he;
  localparam logic [3:0] MODE_FWM  = 4'hb;
  localparam logic [3:0] MODE_MST  = 4'h8;
  localparam logic [3:0] MODE_S10  = 4'h7;
  localparam logic [3:0] MODE_S7   = 4'h6;
  // first five bits of a ten-bit high address byte
  localparam logic [4:0] HI10 = 5'h1e;
  // quarter and bit counts
  localparam logic [1:0] Q_LAST  = 2'h3;
  localparam logic [1:0] Q_SAMP  = 2'h2;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [3:0] BIT_RX7 = 4'h7;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } isp_bus_type;

  typedef enum {
    M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK
  } isp_mst_type;
endpackage

// [design/isp_ctrl.sv]
// i2c master and slave control of the serial port, with registers
// assumes pin inputs synchronous to clock_i and external pull-ups
//
// How it works
// - ten-bit slave flags address rewrite needed
// - received byte sets buffer full; read clears
// - transmit keeps buffer full during data bits
// - master buffer write while busy flags collision
// - slave buffer write mid-send flags collision
// - byte onto full buffer sets overflow
// - enable bit hands pins to the port
// - slave holds clock low while release clear
// - modes 1111/0111 are ten-bit slave
// - modes 1110/0110 are seven-bit slave
// - 1000 master, 1011 firmware master
// - clock rate is osc over 4(n+1)
// - general call answered only when enabled
// - master transmit records slave acknowledge
// - acknowledge value sent in acknowledge sequence
// - acknowledge request runs sequence, self clears
// - receive enable starts master receive
// - stop, restart, start generated, self clear
// - stretch enable adds receive clock stretching
// - requests ignored in master mode unless module idle
// - slave match acks, loads buffer, flags
// - full or overflow withholds ack, keeps buffer
// - address register: slave address or reload
// - idle means no transmit, no request
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module isp_ctrl
  import isp_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire isp_bus_type bus_i,
  output logic [7:0]       rdata_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             port_active_o,
  output logic             serial_irq_o
);
  generate
    if (DIV_W < 1 || DIV_W > 8) begin : g_chk
      $error("DIV_W must be 1 to 8");
    end
  endgenerate

  logic [7:0] con1_reg, con2_reg, addr_reg, buf_reg, shift_reg, rdata_reg;
  logic [1:0] shi_reg;
  logic       bf_reg, ua_reg, da_reg, rw_reg, p_reg, s_reg, irq_reg;
  isp_mst_type m_st_reg;
  logic [1:0] q_reg;
  logic [3:0] mb_reg, sb_reg;
  logic [DIV_W-1:0] div_reg;
  logic       m_scl_reg, m_sda_reg;
  logic       scl_q_reg, sda_q_reg, s_on_reg, s_adr_reg, s_hi_reg;
  logic       s_tx_reg, s_ack_reg, s_sda_reg, s_hit_reg;

  // register strobes
  logic wr_c1, wr_c2, wr_ad, wr_bf, rd_bf, wr_iq;
  assign wr_c1 = bus_i.wr && bus_i.addr == OFS_CON1;
  assign wr_c2 = bus_i.wr && bus_i.addr == OFS_CON2;
  assign wr_ad = bus_i.wr && bus_i.addr == OFS_ADDR;
  assign wr_bf = bus_i.wr && bus_i.addr == OFS_BUF;
  assign rd_bf = bus_i.rd && bus_i.addr == OFS_BUF;
  assign wr_iq = bus_i.wr && bus_i.addr == OFS_IRQ;

  // mode decode
  logic [3:0] mode;
  logic en, is_mst, is_slv, ten, se_irq, clock_release, ov;
  assign mode   = con1_reg[3:0];
  assign en     = con1_reg[B_EN];
  assign clock_release    = con1_reg[B_CKP];
  assign ov     = con1_reg[B_OV];
  assign is_mst = en && mode == MODE_MST;
  assign is_slv = en && (mode == MODE_S7 || mode == MODE_S7I ||
                         mode == MODE_S10 || mode == MODE_S10I);
  assign ten    = mode == MODE_S10 || mode == MODE_S10I;
  assign se_irq = mode == MODE_S7I || mode == MODE_S10I;

  // idle: no transmit and no pending request
  logic tx_busy, idle;
  assign tx_busy = m_st_reg == M_TX;
  assign idle    = !(tx_busy || |con2_reg[4:0]);

  // master sequencing terms
  logic tick, m_last, m_fin, m_samp, m_go;
  assign tick   = m_st_reg != M_IDLE && div_reg == '0;
  assign m_last = m_st_reg == M_TX ? mb_reg == BIT_ACK :
                  m_st_reg == M_RX ? mb_reg == BIT_RX7 : 1'b1;
  assign m_fin  = tick && q_reg == Q_LAST && m_last;
  assign m_samp = tick && q_reg == Q_SAMP;
  assign m_go   = wr_bf && is_mst && idle;

  // slave bus events
  logic scl_rise, scl_fall, start_det, stop_det, s_fall8, s_fall9;
  assign scl_rise  = scl_i && !scl_q_reg;
  assign scl_fall  = !scl_i && scl_q_reg;
  assign start_det = scl_i && scl_q_reg && sda_q_reg && !sda_i;
  assign stop_det  = scl_i && scl_q_reg && !sda_q_reg && sda_i;
  assign s_fall8   = is_slv && scl_fall && sb_reg == BIT_ACK;
  assign s_fall9   = is_slv && scl_fall && sb_reg == BIT_END;

  // byte decision at the eighth falling clock
  logic m7, gc, hit, ok;
  assign m7 = shift_reg[7:1] == addr_reg[7:1];
  assign gc = con2_reg[B_GENERAL_CALL_ENABLE] && shift_reg == 8'h00 && !ten;
  always_comb begin
    if (!s_adr_reg)
      hit = s_on_reg && !s_tx_reg;
    else if (!ten)
      hit = m7 || gc;
    else if (s_hi_reg)
      hit = shift_reg == addr_reg;
    else
      hit = m7 && shift_reg[7:3] == HI10;
  end
  assign ok = s_fall8 && hit && !bf_reg && !ov;

  // control one: software writes, hardware flags
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      con1_reg <= CON_RST;
    end else begin
      if (wr_c1)
        con1_reg <= bus_i.wdata;
      if (wr_bf && ((is_mst && !idle) || (is_slv && s_tx_reg && bf_reg)))
        con1_reg[B_WRITE_COLLISION_FLAG] <= 1'b1;
      if ((s_fall8 && hit && bf_reg) || (m_fin && m_st_reg == M_RX && bf_reg))
        con1_reg[B_OV] <= 1'b1;
      if (s_fall9 && s_tx_reg && !bf_reg)
        con1_reg[B_CKP] <= 1'b0;
      if (s_fall9 && !s_tx_reg && con2_reg[B_SEN] && bf_reg)
        con1_reg[B_CKP] <= 1'b0;
    end
  end

  // control two: requests accepted in master mode only while idle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      con2_reg <= CON_RST;
    end else begin
      if (wr_c2) begin
        con2_reg[7] <= bus_i.wdata[7];
        con2_reg[5] <= bus_i.wdata[5];
        if (!is_mst || idle)
          con2_reg[4:0] <= bus_i.wdata[4:0];
      end
      if (m_samp && m_st_reg == M_TX && mb_reg == BIT_ACK)
        con2_reg[B_AST] <= sda_i;
      if (m_fin) begin
        case (m_st_reg)
          M_START:  con2_reg[0] <= 1'b0;
          M_RSTART: con2_reg[1] <= 1'b0;
          M_STOP:   con2_reg[2] <= 1'b0;
          M_RX:     con2_reg[3] <= 1'b0;
          M_ACK:    con2_reg[4] <= 1'b0;
          default:  ;
        endcase
      end
    end
  end

  // address register and its update flag
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      addr_reg <= CON_RST;
      ua_reg   <= 1'b0;
    end else begin
      if (wr_ad)
        addr_reg <= bus_i.wdata;
      if (wr_ad)
        ua_reg <= 1'b0;
      if (s_fall8 && ten && s_adr_reg && hit && !shift_reg[0])
        ua_reg <= 1'b1;
    end
  end

  // data buffer and buffer full flag
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      buf_reg <= CON_RST;
      bf_reg  <= 1'b0;
    end else begin
      if (rd_bf)
        bf_reg <= 1'b0;
      if (m_fin && m_st_reg == M_RX && !bf_reg && !ov)
        buf_reg <= shift_reg;
      if (m_fin && m_st_reg == M_RX && !bf_reg && !ov)
        bf_reg <= 1'b1;
      if (ok)
        buf_reg <= shift_reg;
      if (ok)
        bf_reg <= 1'b1;
      if (tick && q_reg == Q_LAST && tx_busy && mb_reg == BIT_RX7)
        bf_reg <= 1'b0;
      if (s_fall8 && s_tx_reg && !s_adr_reg)
        bf_reg <= 1'b0;
      if (m_go || (wr_bf && is_slv && !(s_tx_reg && bf_reg))) begin
        buf_reg <= bus_i.wdata;
        bf_reg  <= 1'b1;
      end
    end
  end

  // shift register: master and slave bit movement
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_reg <= CON_RST;
    end else if (m_go || (wr_bf && is_slv && !(s_tx_reg && bf_reg))) begin
      shift_reg <= bus_i.wdata;
    end else if (m_samp && m_st_reg == M_RX) begin
      shift_reg <= {shift_reg[6:0], sda_i};
    end else if (tick && q_reg == Q_LAST && tx_busy && mb_reg < BIT_ACK) begin
      shift_reg <= {shift_reg[6:0], 1'b0};
    end else if (is_slv && scl_rise && sb_reg < BIT_ACK && !s_tx_reg) begin
      shift_reg <= {shift_reg[6:0], sda_i};
    end else if (is_slv && scl_fall && s_tx_reg && sb_reg < BIT_ACK) begin
      shift_reg <= {shift_reg[6:0], 1'b0};
    end
  end

  // master sequencer and quarter-period divider
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      m_st_reg <= M_IDLE;
      q_reg    <= 2'h0;
      mb_reg   <= 4'h0;
      div_reg  <= '0;
    end else if (!is_mst) begin
      m_st_reg <= M_IDLE;
    end else if (m_st_reg == M_IDLE) begin
      q_reg   <= 2'h0;
      mb_reg  <= 4'h0;
      div_reg <= addr_reg[DIV_W-1:0];
      if (con2_reg[0])
        m_st_reg <= M_START;
      else if (con2_reg[1])
        m_st_reg <= M_RSTART;
      else if (con2_reg[2])
        m_st_reg <= M_STOP;
      else if (con2_reg[3])
        m_st_reg <= M_RX;
      else if (con2_reg[4])
        m_st_reg <= M_ACK;
      else if (m_go)
        m_st_reg <= M_TX;
    end else if (tick) begin
      div_reg <= addr_reg[DIV_W-1:0];
      q_reg   <= q_reg + 2'h1;
      if (q_reg == Q_LAST)
        mb_reg <= mb_reg + 4'h1;
      if (m_fin)
        m_st_reg <= M_IDLE;
    end else begin
      div_reg <= div_reg - 1'b1;
    end
  end

  // master pin drive, updated once per quarter
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      m_scl_reg <= 1'b0;
      m_sda_reg <= 1'b0;
    end else if (!is_mst) begin
      m_scl_reg <= 1'b0;
      m_sda_reg <= 1'b0;
    end else if (tick) begin
      case (m_st_reg)
        M_START: begin
          m_sda_reg <= q_reg >= 2'h1;
          m_scl_reg <= q_reg >= 2'h2;
        end
        M_RSTART: begin
          m_scl_reg <= q_reg == 2'h0 || q_reg == Q_LAST;
          m_sda_reg <= q_reg >= 2'h2;
        end
        M_STOP: begin
          m_scl_reg <= q_reg == 2'h0;
          m_sda_reg <= q_reg <= 2'h1;
        end
        M_TX: begin
          m_scl_reg <= q_reg == 2'h0 || q_reg == Q_LAST;
          m_sda_reg <= mb_reg < BIT_ACK && !shift_reg[7];
        end
        M_RX: begin
          m_scl_reg <= q_reg == 2'h0 || q_reg == Q_LAST;
          m_sda_reg <= 1'b0;
        end
        M_ACK: begin
          m_scl_reg <= q_reg == 2'h0 || q_reg == Q_LAST;
          m_sda_reg <= !con2_reg[B_ADT];
        end
        default: begin
          m_scl_reg <= m_scl_reg;
          m_sda_reg <= m_sda_reg;
        end
      endcase
    end
  end

  // slave byte tracking
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      sb_reg    <= 4'h0;
      s_on_reg  <= 1'b0;
      s_adr_reg <= 1'b0;
      s_hi_reg  <= 1'b0;
      s_tx_reg  <= 1'b0;
      s_ack_reg <= 1'b0;
      s_hit_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
      if (!is_slv || stop_det) begin
        sb_reg    <= 4'h0;
        s_on_reg  <= 1'b0;
        s_adr_reg <= 1'b0;
        s_hi_reg  <= 1'b0;
        s_tx_reg  <= 1'b0;
        s_ack_reg <= 1'b0;
      end else if (start_det) begin
        sb_reg    <= 4'h0;
        s_adr_reg <= 1'b1;
        s_tx_reg  <= 1'b0;
      end else if (scl_rise && sb_reg < BIT_END) begin
        sb_reg <= sb_reg + 4'h1;
        if (sb_reg == BIT_ACK && s_tx_reg && sda_i) begin
          s_on_reg <= 1'b0; // master refused: back to listening
          s_tx_reg <= 1'b0;
        end
      end else if (s_fall8) begin
        s_ack_reg <= ok;
        s_hit_reg <= hit;
        if (hit && s_adr_reg) begin
          s_on_reg <= 1'b1;
          s_tx_reg <= shift_reg[0] && !gc;
          if (ten && !s_hi_reg && !shift_reg[0])
            s_hi_reg <= 1'b1;
          else
            s_adr_reg <= 1'b0;
          if (ten && s_hi_reg)
            s_hi_reg <= 1'b0;
        end
      end else if (s_fall9) begin
        sb_reg    <= 4'h0;
        s_ack_reg <= 1'b0;
        s_hit_reg <= 1'b0;
      end
    end
  end

  // slave status bits and irq flag
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      da_reg  <= 1'b0;
      rw_reg  <= 1'b0;
      p_reg   <= 1'b0;
      s_reg   <= 1'b0;
      irq_reg <= 1'b0;
      shi_reg <= 2'h0;
    end else begin
      if (bus_i.wr && bus_i.addr == OFS_STAT)
        shi_reg <= bus_i.wdata[7:6];
      if (!en) begin
        p_reg <= 1'b0;
        s_reg <= 1'b0;
      end else if (start_det || stop_det) begin
        p_reg <= stop_det;
        s_reg <= start_det;
      end
      if (s_fall8 && hit)
        da_reg <= !s_adr_reg;
      if (s_fall8 && hit && s_adr_reg)
        rw_reg <= shift_reg[0];
      if (wr_iq && bus_i.wdata[0])
        irq_reg <= 1'b0;
      if ((s_fall9 && s_hit_reg) || m_fin ||
          (is_slv && se_irq && (start_det || stop_det)))
        irq_reg <= 1'b1;
    end
  end

  // slave data drive on sda
  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      s_sda_reg <= 1'b0;
    else
      s_sda_reg <= is_slv && (s_ack_reg ||
                   (s_tx_reg && s_on_reg && sb_reg < BIT_ACK && !shift_reg[7]));
  end

  // register read, data the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !bus_i.rd) begin
      rdata_reg <= 8'h00;
    end else begin
      case (bus_i.addr)
        OFS_STAT: rdata_reg <= {shi_reg, da_reg, p_reg, s_reg,
                                is_mst ? tx_busy : rw_reg, ua_reg, bf_reg};
        OFS_CON1: rdata_reg <= con1_reg;
        OFS_CON2: rdata_reg <= con2_reg;
        OFS_ADDR: rdata_reg <= addr_reg;
        OFS_BUF:  rdata_reg <= buf_reg;
        OFS_IRQ:  rdata_reg <= {7'h00, irq_reg};
        default:  rdata_reg <= 8'h00;
      endcase
    end
  end

  // open-drain pins: only ever pulled low
  assign scl_o         = 1'b0;
  assign sda_o         = 1'b0;
  assign scl_oe_o      = en && (is_mst ? m_scl_reg :
                         is_slv && (!clock_release || (ten && ua_reg)));
  assign sda_oe_o      = en && (is_mst ? m_sda_reg : s_sda_reg);
  assign port_active_o = en;
  assign serial_irq_o  = irq_reg;
  assign rdata_o       = rdata_reg;

  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_bf_rd;
    rd_bf && !ok && !m_go && !wr_bf && !m_fin |=> !bf_reg;
  endproperty
  a_bf_rd: assert property (p_bf_rd) else $error("read kept full");
  property p_ov;
    s_fall8 && hit && bf_reg |=> ov && !s_ack_reg;
  endproperty
  a_ov: assert property (p_ov) else $error("no overflow");
  property p_keep;
    s_fall8 && (bf_reg || ov) && !wr_bf |=> $stable(buf_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("buffer changed");
  property p_write_collision_flag;
    wr_bf && is_mst && !idle |=> con1_reg[B_WRITE_COLLISION_FLAG];
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("no collision");
  property p_pins;
    !en |-> !scl_oe_o && !sda_oe_o;
  endproperty
  a_pins: assert property (p_pins) else $error("pins driven off");
  property p_ckp;
    is_slv && !clock_release |-> scl_oe_o;
  endproperty
  a_ckp: assert property (p_ckp) else $error("clock not held");
  property p_sen;
    m_fin && m_st_reg == M_START |=> !con2_reg[0] && m_st_reg == M_IDLE;
  endproperty
  a_sen: assert property (p_sen) else $error("start not cleared");
  property p_div;
    tick && m_st_reg != M_IDLE && !m_fin |=> div_reg == addr_reg[DIV_W-1:0];
  endproperty
  a_div: assert property (p_div) else $error("bad reload");
  property p_busy;
    wr_c2 && is_mst && !idle && !con2_reg[0] |=> !con2_reg[0];
  endproperty
  a_busy: assert property (p_busy) else $error("request queued");
  property p_ua;
    wr_ad && !s_fall8 |=> !ua_reg;
  endproperty
  a_ua: assert property (p_ua) else $error("update flag stuck");

  c_start: cover property (m_fin && m_st_reg == M_START);
  c_hit:   cover property (ok);
  c_ovf:   cover property (s_fall8 && hit && bf_reg);
endmodule

// [tb/isp_peer_model.sv]
// far side of the bus: a master that stretches-aware clocks bytes out,
// and a slave that captures bytes and answers with ack or nack
// assumes wired-and lines with pull-ups built by the bench
`timescale 1ns/1ps
module isp_peer_model (
  input  wire logic clock_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_oe_o,
  output logic      sda_oe_o
);
  int         half   = 8;
  logic       slv_on = 1'b0;
  logic       nack_mode = 1'b0;
  logic       hung   = 1'b0;
  logic [7:0] got    = 8'h00;
  logic [3:0] cnt    = 4'h0;
  logic       ps     = 1'b1;
  logic       pd     = 1'b1;
  int         starts = 0;
  int         stops  = 0;

  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // release clock and wait while the device stretches it
  task automatic scl_up();
    int k;
    k = 0;
    scl_oe_o <= 1'b0;
    do begin
      @(posedge clock_i);
      k++;
    end while (!scl_i && k < 4000);
    if (k >= 4000) hung = 1'b1;
  endtask

  task automatic m_start();
    sda_oe_o <= 1'b1;
    tick(half);
    scl_oe_o <= 1'b1;
    tick(half);
  endtask

  task automatic m_bit(input logic b, output logic r);
    sda_oe_o <= !b;
    tick(half);
    scl_up();
    tick(half / 2);
    r = sda_i;
    tick(half / 2);
    scl_oe_o <= 1'b1;
  endtask

  // msb first, then one released bit for the answer
  task automatic m_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) m_bit(b[i], r);
    m_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic m_stop();
    sda_oe_o <= 1'b1;
    tick(half);
    scl_up();
    tick(half);
    sda_oe_o <= 1'b0;
    tick(half);
  endtask

  // slave role: shift on clock rise, ack after the 8th fall
  always @(posedge clock_i) begin
    ps <= scl_i;
    pd <= sda_i;
    if (slv_on) begin
      if (ps && scl_i && pd && !sda_i) begin
        cnt <= 4'hf;
        starts <= starts + 1;
      end else if (!ps && scl_i && cnt < 4'h8) begin
        got <= {got[6:0], sda_i};
      end else if (ps && !scl_i) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h7) sda_oe_o <= !nack_mode;
        if (cnt == 4'h8) sda_oe_o <= 1'b0;
      end
      if (ps && scl_i && !pd && sda_i) stops <= stops + 1;
    end
  end
endmodule

// [tb/i2c_master_slave_port_control_tb.sv]
// self-checking bench of the serial port control block
// assumes open-drain lines with pull-ups and the peer model beside it
`timescale 1ns/1ps
module i2c_master_slave_port_control_tb;
  import isp_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  isp_bus_type bus     = '0;
  logic [7:0]  rdata_o;
  logic        scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic        port_active_o, serial_irq_o;
  wire logic   scl_w, sda_w;
  logic        p_scl, p_sda, ak, sp;
  logic [7:0]  d, b;
  int          failures = 0;
  int          num_checks = 0;
  int          seed = 87079;
  int          cyc = 0;
  int          lr = 0;
  int          per = 0;

  always #2 clock_i = !clock_i;

  // wired-and lines with pull-ups
  assign scl_w = (scl_oe_o ? scl_o : 1'b1) & !p_scl;
  assign sda_w = (sda_oe_o ? sda_o : 1'b1) & !p_sda;

  isp_ctrl #(.DIV_W(7)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .port_active_o(port_active_o),
    .serial_irq_o(serial_irq_o));

  isp_peer_model peer (
    .clock_i(clock_i), .scl_i(scl_w), .sda_i(sda_w),
    .scl_oe_o(p_scl), .sda_oe_o(p_sda));

  // clock period seen on the wire, in cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    sp  <= scl_w;
    if (!sp && scl_w) begin
      per <= cyc - lr;
      lr  <= cyc;
    end
  end

  function automatic logic [7:0] con1(input logic en, clock_release, input logic [3:0] m);
    return {2'b00, en, clock_release, m};
  endfunction

  function automatic int exp_per(input int a);
    return 4 * (a + 1);
  endfunction

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock_i);
    bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    bus <= '0;
    #1 v = rdata_o;
  endtask

  // wait until the masked bits of a register read back clear
  task automatic poll(input logic [2:0] a, input logic [7:0] m);
    int k;
    k = 0;
    do begin
      rd(a, d);
      k++;
    end while ((d & m) !== 8'h00 && k < 2000);
    if (k >= 2000) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict();
    end
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // reset values, unmapped index, mode codes
    rd(OFS_CON1, d); chk(d, CON_RST);
    rd(OFS_CON2, d); chk(d, CON_RST);
    chk(port_active_o, 0);
    wr(3'h6, 8'h5a);
    rd(3'h6, d); chk(d, 8'h00);
    for (int i = 0; i < 6; i++) begin
      b = con1(0, 0, i[0] ? (i[1] ? MODE_S10I : MODE_S7I) : (i[1] ? MODE_S10 : MODE_S7));
      if (i > 3) b = con1(0, 0, i == 4 ? MODE_MST : MODE_FWM);
      wr(OFS_CON1, b);
      rd(OFS_CON1, d); chk(d, b);
    end
    // hardware master, quarter of two cycles
    peer.slv_on = 1'b1;
    wr(OFS_ADDR, 8'h01);
    wr(OFS_CON1, con1(1, 0, MODE_MST));
    chk(port_active_o, 1);
    wr(OFS_CON2, 8'h01);
    wr(OFS_BUF, 8'h77);
    rd(OFS_CON1, d); chk(d[B_WRITE_COLLISION_FLAG], 1);
    poll(OFS_CON2, 8'h1f);
    chk(peer.starts, 1);
    wr(OFS_CON1, con1(1, 0, MODE_MST));
    for (int i = 0; i < 2; i++) begin
      peer.nack_mode = i[0];
      b = 8'($random(seed));
      wr(OFS_BUF, b);
      rd(OFS_STAT, d); chk(d[B_BF], 1);
      wr(OFS_CON2, 8'h01);
      repeat (4) @(posedge clock_i);
      poll(OFS_STAT, 8'h04);
      chk(d[B_BF], 0);
      chk(peer.got, b);
      chk(per, exp_per(1));
      rd(OFS_CON2, d); chk(d[B_AST], i);
      chk(d[B_SEN], 0);
    end
    // master receive of a released line, then an acknowledge sequence
    wr(OFS_CON2, 8'h08);
    poll(OFS_CON2, 8'h1f);
    rd(OFS_BUF, d); chk(d, 8'hff);
    wr(OFS_CON2, 8'h10);
    poll(OFS_CON2, 8'h1f);
    wr(OFS_CON2, 8'h04);
    poll(OFS_CON2, 8'h1f);
    chk(peer.stops, 1);
    // seven-bit slave with clock released
    peer.slv_on = 1'b0;
    wr(OFS_CON1, 8'h00);
    wr(OFS_ADDR, 8'h5a);
    wr(OFS_CON1, con1(1, 1, MODE_S7));
    wr(OFS_CON2, 8'h01);
    peer.m_start();
    peer.m_byte(8'h5a, ak);
    repeat (2) @(posedge clock_i);
    chk(ak, 1);
    chk(serial_irq_o, 1);
    rd(OFS_STAT, d); chk(d[B_BF], 1);
    wr(OFS_IRQ, 8'h01);
    chk(serial_irq_o, 0);
    rd(OFS_CON1, d); chk(d[B_CKP], 0);
    fork
      peer.m_byte(8'hc3, ak);
      begin
        repeat (80) @(posedge clock_i);
        chk(scl_w, 0);
        wr(OFS_CON1, con1(1, 1, MODE_S7));
      end
    join
    repeat (2) @(posedge clock_i);
    chk(ak, 0);
    chk(serial_irq_o, 1);
    rd(OFS_CON1, d); chk(d[B_OV], 1);
    rd(OFS_BUF, d); chk(d, 8'h5a);
    rd(OFS_STAT, d); chk(d[B_BF], 0);
    wr(OFS_CON1, con1(1, 1, MODE_S7));
    peer.m_stop();
    // firmware master leaves the pins alone
    wr(OFS_CON1, con1(1, 0, MODE_FWM));
    wr(OFS_CON2, 8'h01);
    repeat (40) @(posedge clock_i);
    chk({scl_oe_o, sda_oe_o}, 0);
    wr(OFS_CON1, 8'h00);
    chk(port_active_o, 0);
    chk(peer.hung, 0);
    print_verdict();
  end
endmodule
